// File: haptic_consts.svh
// Register offsets, reset values, bus addresses and timing counts of the loop control
`ifndef HAPTIC_CONSTS_SVH
`define HAPTIC_CONSTS_SVH
`define OFS_STATUS      8'h00
`define OFS_MODE        8'h01
`define OFS_GO          8'h0C
`define OFS_STEADY      8'h16
`define OFS_PEAK        8'h17
`define OFS_ACT         8'h1A
`define OFS_DRIVE       8'h1B
`define OFS_TIMING      8'h1C
`define OFS_LOOP        8'h1D
`define ADDR_OWN        7'h5A
`define ADDR_BCAST      7'h58
`define MODE_INT_TRIG   3'h0
`define MODE_DIAG       3'h6
`define MODE_CAL        3'h7
`define RST_MODE        3'h0
`define RST_STANDBY     1'b1
`define RST_STEADY      8'h40
`define RST_PEAK        8'h80
`define RST_DRIVE       5'h10
`define RST_DECAY       2'h1
`define RST_SETTLE      2'h1
`define CLK_HZ          40000000
`define DRIVE_STEP_US   100
`define DRIVE_STEP_CYC  ((`DRIVE_STEP_US * `CLK_HZ) / 1000000)
`define DECAY_STEP_US   25
`define DECAY_STEP_CYC  ((`DECAY_STEP_US * `CLK_HZ) / 1000000)
`define SETTLE_STEP_US  25
`define SETTLE_STEP_CYC ((`SETTLE_STEP_US * `CLK_HZ) / 1000000)
`define TRIM_CYC        20'h00064
`endif

// File: haptic_pkg.sv
// Types shared by the haptic loop control
package haptic_pkg;
  // Drive process phases
  typedef enum logic [2:0] {P_IDLE, P_DRIVE, P_DECAY, P_SETTLE, P_CONVERT} proc_state_t;
  // Two-wire slave phases
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_AACK, S_PTR, S_PACK, S_WR, S_WACK, S_RD, S_RACK
  } bus_state_t;
  // Software-visible configuration
  typedef struct packed {
    logic [2:0] mode;
    logic       standby;
    logic       go;
    logic [7:0] steady;
    logic [7:0] peak;
    logic       linear_resonant_actuator;
    logic [4:0] drive_code;
    logic [1:0] decay_code;
    logic [1:0] settle_code;
    logic       open_loop;
  } cfg_t;
  // Output stage controls
  typedef struct packed {
    logic drive_p;
    logic drive_n;
    logic hiz;
    logic adc_start;
  } stage_t;
endpackage : haptic_pkg

// File: haptic_drive_loop_control.sv
// Haptic drive loop control: two-wire register slave, fault handling, back-EMF sequencing
// What this block does
// R1: Output short sets flag, held, current cut
// R2: Shorts checked only while a process runs
// R3: Idle short reported at next run attempt
// R4: Regulator short shuts down, restarts at defaults
// R5: Open-loop resonant drive keeps toggling at rate
// R6: Half-period code seeds resonant drive, then trimmed
// R7: Rotating mass: code sets back-EMF sample interval
// R8: Current decays for coded interval before high-Z
// R9: Settle wait coded before back-EMF conversion
// R10: Closed loop uses steady-level target register
// R11: Open loop uses peak limit as reference
// R12: Peak limit bounds output in every mode
// R13: Steady target above peak gets peak
// R14: Host writes both levels before calibration
// R15: Broadcast bus address also accepted
// R16: Broadcast go write starts all drivers together
// R17: Own bus address accepted
// R18: Host writes one to trigger register
// R19: Codes mapped to cycle counts by tables
`include "haptic_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module haptic_drive_loop_control
#(
  parameter int DRIVE_STEP_CYC = `DRIVE_STEP_CYC  // Cycles per half-period code step
)
(
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  // Two-wire bus pins
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output var  logic              sda_o,
  output var  logic              sda_oe_o,
  // Analog fault comparators
  input  wire logic              out_short_i,
  input  wire logic              reg_short_i,
  // Back-EMF converter
  input  wire logic              adc_done_i,
  input  wire logic              bemf_late_i,
  // Output stage and status
  output var  haptic_pkg::stage_t stage_o,
  output var  logic [7:0]        full_scale_o,
  output var  logic              short_flag_o,
  output var  logic              busy_o
);
  import haptic_pkg::*;

  localparam cfg_t CFG_RST = '{mode: `RST_MODE, standby: `RST_STANDBY, go: 1'b0,
    steady: `RST_STEADY, peak: `RST_PEAK, linear_resonant_actuator: 1'b0, drive_code: `RST_DRIVE,
    decay_code: `RST_DECAY, settle_code: `RST_SETTLE, open_loop: 1'b0};

  // Synchronisers for pins and comparators
  logic [1:0]  scl_sync_q, sda_sync_q, osh_sync_q, rsh_sync_q;
  logic        scl_prev_q, sda_prev_q;      // Previous synced levels
  logic        scl_s, sda_s, short_s, reg_short_s;
  // Bus slave state
  bus_state_t  bus_q, bus_d;
  logic [2:0]  bit_q, bit_d;                // Bit within byte
  logic [7:0]  shift_q, shift_d;            // Byte shifter
  logic [7:0]  ptr_q, ptr_d;                // Register pointer
  logic        rw_q, rw_d;                  // Read transfer
  logic        armed_q, armed_d;            // SCL rose since last start
  logic        oe_q, oe_d;                  // Pulling data low
  logic        wr_stb;                      // Register write this cycle
  logic        scl_rise, scl_fall, start_c, stop_c;
  // Configuration and process state
  cfg_t        cfg_q, cfg_d;
  proc_state_t proc_q, proc_d;
  logic [19:0] cnt_q, cnt_d;                // Phase countdown
  logic [19:0] len_q, len_d;                // Effective half-period
  logic        pol_q, pol_d;                // Drive polarity
  logic        flag_q, flag_d;              // Output short flag
  stage_t      stage_d;
  logic [7:0]  fs_d;
  logic        run_req, short_hit, runnable;

  // Half-period table in cycles
  function automatic logic [19:0] drive_cyc(input logic [4:0] code);
    drive_cyc = 20'((int'(code) + 1) * DRIVE_STEP_CYC);
  endfunction : drive_cyc

  // Decay and settle tables in cycles
  function automatic logic [19:0] wait_cyc(input logic [1:0] code, input int step);
    wait_cyc = 20'((int'(code) + 1) * step);
  endfunction : wait_cyc

  // Register read decode
  function automatic logic [7:0] reg_read(input logic [7:0] a, input cfg_t c,
                                          input logic flag, input logic busy);
    case (a)
      `OFS_STATUS: reg_read = {6'h00, busy, flag};
      `OFS_MODE:   reg_read = {1'b0, c.standby, 3'h0, c.mode};
      `OFS_GO:     reg_read = {7'h00, c.go};
      `OFS_STEADY: reg_read = c.steady;
      `OFS_PEAK:   reg_read = c.peak;
      `OFS_ACT:    reg_read = {c.linear_resonant_actuator, 7'h00};
      `OFS_DRIVE:  reg_read = {3'h0, c.drive_code};
      `OFS_TIMING: reg_read = {4'h0, c.settle_code, c.decay_code};
      `OFS_LOOP:   reg_read = {7'h00, c.open_loop};
      default:     reg_read = 8'h00;            // Unmapped reads zero
    endcase
  endfunction : reg_read

  assign scl_s       = scl_sync_q[1];
  assign sda_s       = sda_sync_q[1];
  assign short_s     = osh_sync_q[1];
  assign reg_short_s = rsh_sync_q[1];
  assign scl_rise    = scl_s & ~scl_prev_q;
  assign scl_fall    = ~scl_s & scl_prev_q;
  assign start_c     = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_c      = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // Two-flop synchronisers
  always_ff @(posedge clk_sys_i or negedge nrst_i)
    if (!nrst_i)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      osh_sync_q <= 2'h0;
      rsh_sync_q <= 2'h0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      osh_sync_q <= {osh_sync_q[0], out_short_i};
      rsh_sync_q <= {rsh_sync_q[0], reg_short_i};
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end

  // Bus slave next state
  always_comb
  begin
    bus_d   = bus_q;
    bit_d   = bit_q;
    shift_d = shift_q;
    ptr_d   = ptr_q;
    rw_d    = rw_q;
    oe_d    = oe_q;
    wr_stb  = 1'b0;
    armed_d = armed_q;
    if (start_c)
    begin
      bus_d   = S_ADDR;                         // Start or repeated start
      bit_d   = 3'h0;
      armed_d = 1'b0;                           // Next fall closes the start, not a bit
      oe_d  = 1'b0;
    end
    else if (stop_c || reg_short_s)
    begin
      bus_d = S_IDLE;
      oe_d  = 1'b0;
    end
    else if (scl_rise && (bus_q == S_ADDR || bus_q == S_PTR || bus_q == S_WR))
      shift_d = {shift_q[6:0], sda_s};          // Sample data on high clock
    else if (scl_rise && bus_q == S_RACK && sda_s)
      bus_d = S_IDLE;                           // Master not-acknowledge ends read
    else if (scl_fall && armed_q)               // Only falls that end a clocked bit
    begin
      bit_d = bit_q + 3'h1;
      unique case (bus_q)
        S_IDLE: ;
        S_ADDR:
          if (bit_q == 3'h7)
          begin
            // Own and broadcast addresses both answered [R15] [R17]
            if (shift_q[7:1] == `ADDR_OWN || shift_q[7:1] == `ADDR_BCAST)
            begin
              bus_d = S_AACK;
              rw_d  = shift_q[0];
              oe_d  = 1'b1;
            end
            else
              bus_d = S_IDLE;
          end
        S_AACK:
          if (rw_q)
          begin
            bus_d   = S_RD;
            bit_d   = 3'h0;
            shift_d = reg_read(ptr_q, cfg_q, flag_q, busy_o);
            oe_d    = ~shift_d[7];
          end
          else
          begin
            bus_d = S_PTR;
            bit_d = 3'h0;
            oe_d  = 1'b0;
          end
        S_PTR:
          if (bit_q == 3'h7)
          begin
            bus_d = S_PACK;
            ptr_d = shift_q;
            oe_d  = 1'b1;
          end
        S_PACK, S_WACK:
        begin
          bus_d = S_WR;
          bit_d = 3'h0;
          oe_d  = 1'b0;
        end
        S_WR:
          if (bit_q == 3'h7)
          begin
            bus_d  = S_WACK;
            wr_stb = 1'b1;                      // Byte lands at pointer
            oe_d   = 1'b1;
          end
        S_RD:
          if (bit_q == 3'h7)
          begin
            bus_d = S_RACK;
            oe_d  = 1'b0;
          end
          else
          begin
            shift_d = {shift_q[6:0], 1'b0};
            oe_d    = ~shift_q[6];
          end
        S_RACK:
        begin
          bus_d   = S_RD;
          bit_d   = 3'h0;
          ptr_d   = ptr_q + 8'h01;              // Sequential read
          shift_d = reg_read(ptr_d, cfg_q, flag_q, busy_o);
          oe_d    = ~shift_d[7];
        end
      endcase
    end
    if (scl_rise)
      armed_d = 1'b1;                           // A bit has been clocked
    if (wr_stb)
      ptr_d = ptr_q + 8'h01;                    // Sequential write
  end

  // Bus slave registers
  always_ff @(posedge clk_sys_i or negedge nrst_i)
    if (!nrst_i)
    begin
      bus_q   <= S_IDLE;
      bit_q   <= 3'h0;
      shift_q <= 8'h00;
      ptr_q   <= 8'h00;
      rw_q    <= 1'b0;
      armed_q <= 1'b0;
      oe_q    <= 1'b0;
    end
    else
    begin
      bus_q   <= bus_d;
      bit_q   <= bit_d;
      shift_q <= shift_d;
      ptr_q   <= ptr_d;
      rw_q    <= rw_d;
      armed_q <= armed_d;
      oe_q    <= oe_d;
    end

  assign runnable  = cfg_q.mode == `MODE_INT_TRIG || cfg_q.mode == `MODE_DIAG ||
                     cfg_q.mode == `MODE_CAL;
  assign run_req   = proc_q == P_IDLE && cfg_q.go && !cfg_q.standby && runnable;
  // Shorts seen only while running or attempting to run [R2] [R3]
  assign short_hit = short_s && (proc_q != P_IDLE || run_req);

  // Register file and process sequencer next state
  always_comb
  begin
    cfg_d   = cfg_q;
    proc_d  = proc_q;
    cnt_d   = cnt_q - 20'h1;
    len_d   = len_q;
    pol_d   = pol_q;
    if (wr_stb)
    begin
      unique case (ptr_q)
        `OFS_MODE:   {cfg_d.standby, cfg_d.mode} = {shift_q[6], shift_q[2:0]};
        `OFS_GO:     cfg_d.go = shift_q[0];     // Broadcast write fires all at once [R16] [R18]
        `OFS_STEADY: cfg_d.steady = shift_q;
        `OFS_PEAK:   cfg_d.peak = shift_q;
        `OFS_ACT:    cfg_d.linear_resonant_actuator = shift_q[7];
        `OFS_DRIVE:  cfg_d.drive_code = shift_q[4:0];
        `OFS_TIMING: {cfg_d.settle_code, cfg_d.decay_code} = shift_q[3:0];
        `OFS_LOOP:   cfg_d.open_loop = shift_q[0];
        default: ;                              // Other writes ignored
      endcase
    end
    unique case (proc_q)
      P_IDLE:
        if (run_req)
        begin
          proc_d = P_DRIVE;
          cnt_d  = drive_cyc(cfg_q.drive_code); // Code seeds half-period [R6] [R7] [R19]
          len_d  = drive_cyc(cfg_q.drive_code);
          pol_d  = 1'b0;
        end
        else
          cnt_d = cnt_q;
      P_DRIVE:
        if (cnt_q == 20'h1 && cfg_q.open_loop)
        begin
          pol_d = ~pol_q;                       // Keep toggling, no sensing [R5]
          cnt_d = len_q;
        end
        else if (cnt_q == 20'h1)
        begin
          proc_d = P_DECAY;                     // Let current decay first [R8] [R19]
          cnt_d  = wait_cyc(cfg_q.decay_code, `DECAY_STEP_CYC);
        end
      P_DECAY:
        if (cnt_q == 20'h1)
        begin
          proc_d = P_SETTLE;                    // High-Z only after decay [R8] [R9]
          cnt_d  = wait_cyc(cfg_q.settle_code, `SETTLE_STEP_CYC);
        end
      P_SETTLE:
        if (cnt_q == 20'h1)
          proc_d = P_CONVERT;                   // Conversion after settle [R9]
      P_CONVERT:
      begin
        cnt_d = len_q;
        if (adc_done_i)
        begin
          proc_d = P_DRIVE;
          pol_d  = ~pol_q;
          // Resonant actuator: trim half-period toward optimum [R6]
          if (cfg_q.linear_resonant_actuator && bemf_late_i)
            len_d = len_q + `TRIM_CYC;
          else if (cfg_q.linear_resonant_actuator && len_q > `TRIM_CYC)
            len_d = len_q - `TRIM_CYC;
          cnt_d = len_d;
        end
      end
      default: proc_d = P_IDLE;
    endcase
    // Short aborts the process and drops go [R1]
    if (short_hit)
      cfg_d.go = 1'b0;
    if (short_hit || !cfg_q.go || cfg_q.standby)
      proc_d = P_IDLE;
    // Regulator short: shut down, come back at defaults [R4]
    if (reg_short_s)
    begin
      cfg_d  = CFG_RST;
      proc_d = P_IDLE;
    end
    // Flag held while short persists [R1]
    flag_d  = short_s && (flag_q || short_hit) && !reg_short_s;
    stage_d.drive_p   = proc_d == P_DRIVE && !pol_d;
    stage_d.drive_n   = proc_d == P_DRIVE && pol_d;
    stage_d.hiz       = proc_d == P_SETTLE || proc_d == P_CONVERT;
    stage_d.adc_start = proc_q == P_SETTLE && proc_d == P_CONVERT;
    // Reference: peak in open loop, steady clamped by peak otherwise [R10] [R11] [R12] [R13]
    if (cfg_d.open_loop || cfg_d.steady > cfg_d.peak)
      fs_d = cfg_d.peak;
    else
      fs_d = cfg_d.steady;
  end

  // Register file, sequencer and output flops
  always_ff @(posedge clk_sys_i or negedge nrst_i)
    if (!nrst_i)
    begin
      cfg_q        <= CFG_RST;
      proc_q       <= P_IDLE;
      cnt_q        <= 20'h0;
      len_q        <= 20'h0;
      pol_q        <= 1'b0;
      flag_q       <= 1'b0;
      stage_o      <= '0;
      full_scale_o <= 8'h00;
      short_flag_o <= 1'b0;
      busy_o       <= 1'b0;
      sda_o        <= 1'b0;
      sda_oe_o     <= 1'b0;
    end
    else
    begin
      cfg_q        <= cfg_d;
      proc_q       <= proc_d;
      cnt_q        <= cnt_d;
      len_q        <= len_d;
      pol_q        <= pol_d;
      flag_q       <= flag_d;
      stage_o      <= stage_d;
      full_scale_o <= fs_d;
      short_flag_o <= flag_d;
      busy_o       <= proc_d != P_IDLE;
      sda_o        <= 1'b0;                     // Open drain, only pulls low
      sda_oe_o     <= oe_d;
    end

  // Checks on this block
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  AST_SHORT_SETS_FLAG: assert property (short_hit && !reg_short_s |=> short_flag_o) // [R1]
    else $error("short during process did not set flag");
  AST_SHORT_STOPS: assert property (proc_q != P_IDLE && short_s |=> proc_q == P_IDLE && !stage_o.drive_p && !stage_o.drive_n) // [R1]
    else $error("short did not cut drive");
  AST_FLAG_DROPS: assert property (!short_s |=> !short_flag_o) // [R1]
    else $error("flag held without short");
  AST_IDLE_SILENT: assert property (proc_q == P_IDLE && !run_req && !flag_q |=> !short_flag_o) // [R2] [R3]
    else $error("short reported while idle");
  AST_REG_DEFAULT: assert property (reg_short_s |=> cfg_q == CFG_RST && !busy_o) // [R4]
    else $error("regulator short did not restore defaults");
  AST_DECAY_BEFORE_HIZ: assert property ($rose(stage_o.hiz) |-> $past(proc_q, 2) == P_DECAY) // [R8]
    else $error("high impedance without decay");
  AST_CONV_AFTER_SETTLE: assert property (stage_o.adc_start |-> $past(proc_q, 2) == P_SETTLE && stage_o.hiz) // [R9]
    else $error("conversion started without settle");
  AST_PEAK_BOUND: assert property (full_scale_o <= cfg_q.peak) // [R12] [R13]
    else $error("full scale above peak limit");
  AST_OPEN_REF: assert property (cfg_d.open_loop |=> full_scale_o == $past(cfg_d.peak)) // [R11]
    else $error("open loop not using peak");
  AST_CLOSED_REF: assert property (!cfg_d.open_loop && cfg_d.steady <= cfg_d.peak |=> full_scale_o == $past(cfg_d.steady)) // [R10]
    else $error("closed loop not using steady target");
  AST_ADDR_ACK: assert property (bus_q == S_AACK |-> sda_oe_o) // [R15] [R17]
    else $error("matched address not acknowledged");

  COV_RUN: cover property (run_req ##1 proc_q == P_DRIVE);
  COV_CONVERT: cover property (stage_o.adc_start);
  COV_SHORT: cover property (short_hit);
  COV_READ: cover property (bus_q == S_RACK);
endmodule : haptic_drive_loop_control
`default_nettype wire

// File: actuator_model.sv
// Actuator and back-EMF converter model facing the haptic loop control
`timescale 1ns/10ps
`default_nettype none
module actuator_model
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  // Output stage and behaviour knobs
  input  wire haptic_pkg::stage_t stage_i,
  input  wire logic               slow_i,
  input  wire logic               late_i,
  // Converter answers
  output var  logic               adc_done_o,
  output var  logic               bemf_late_o
);
  import haptic_pkg::*;
  logic [7:0] wait_q;  // Conversion countdown
  // Answers a conversion only while the outputs float
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wait_q      <= 8'h00;
      adc_done_o  <= 1'b0;
      bemf_late_o <= 1'b0;
    end
    else
    begin
      adc_done_o  <= 1'b0;
      bemf_late_o <= ~bemf_late_o;  // Meaningless outside the done cycle
      if (stage_i.adc_start)
        wait_q <= slow_i ? 8'h28 : 8'h03;  // Slow or prompt converter
      else if (wait_q == 8'h01 && stage_i.hiz)
      begin
        wait_q      <= 8'h00;
        adc_done_o  <= 1'b1;
        bemf_late_o <= late_i;
      end
      else if (wait_q != 8'h00)
        wait_q <= wait_q - 8'h01;
    end
  end
endmodule : actuator_model
`default_nettype wire

// File: test_haptic_drive_loop_control.sv
// Self-checking bench for the haptic drive loop control
`timescale 1ns/10ps
`default_nettype none
`include "haptic_consts.svh"
module test_haptic_drive_loop_control;
  import haptic_pkg::*;
  logic       clk_sys = 1'b0;    // 40 MHz clock
  logic       nrst = 1'b0;       // Active-low reset
  logic       scl = 1'b1;        // Bus clock pin
  logic       sda_m = 1'b1;      // Master data, 1 releases
  logic       out_short = 1'b0;  // Output short comparator
  logic       reg_short = 1'b0;  // Regulator short comparator
  logic       slow = 1'b0;       // Slow converter answers
  logic       late = 1'b0;       // Back-EMF late indication
  wire logic  sda_oe;            // Slave pulls data low
  wire logic  adc_done;          // Conversion done
  wire logic  bemf_late;         // Late flag from model
  wire logic  flag;              // Output short flag
  wire logic  busy;              // Process running
  stage_t     stage;             // Output stage controls
  logic [7:0] full;              // Drive reference
  wire logic  sda_out;           // Slave data value when driving
  wire logic  sda_w = sda_m & (~sda_oe | sda_out);  // Wired-AND line with pull-up
  int         fail_count = 0;
  int         n_checks = 0;
  int         cyc = 0;

  haptic_drive_loop_control #(.DRIVE_STEP_CYC(4)) dut
  (
    .clk_sys_i    (clk_sys),
    .nrst_i       (nrst),
    .scl_i        (scl),
    .sda_i        (sda_w),
    .sda_o        (sda_out),
    .sda_oe_o     (sda_oe),
    .out_short_i  (out_short),
    .reg_short_i  (reg_short),
    .adc_done_i   (adc_done),
    .bemf_late_i  (bemf_late),
    .stage_o      (stage),
    .full_scale_o (full),
    .short_flag_o (flag),
    .busy_o       (busy)
  );
  actuator_model model
  (
    .clk_i       (clk_sys),
    .nrst_i      (nrst),
    .stage_i     (stage),
    .slow_i      (slow),
    .late_i      (late),
    .adc_done_o  (adc_done),
    .bemf_late_o (bemf_late)
  );

  // Clock generator
  always #12.5 clk_sys = ~clk_sys;

  // Watchdog against hangs
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      fail_count++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic w(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : w

  // Compare a design value
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // Compare a measured cycle count, one cycle of slack
  task automatic near(input string nm, input int e, input int g);
    n_checks++;
    if (g < e - 1 || g > e + 1)
    begin
      fail_count++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask : near

  // One bus bit, 12 clocks long
  task automatic bit_x(input logic b, output logic r);
    sda_m = b;
    w(3);
    scl = 1'b1;
    w(3);
    r = sda_w;
    w(3);
    scl = 1'b0;
    w(3);
  endtask : bit_x

  task automatic st;
    sda_m = 1'b1;
    w(3);
    scl = 1'b1;
    w(6);
    sda_m = 1'b0;
    w(6);
    scl = 1'b0;
    w(3);
  endtask : st

  task automatic sp;
    sda_m = 1'b0;
    w(3);
    scl = 1'b1;
    w(6);
    sda_m = 1'b1;
    w(6);
  endtask : sp

  task automatic byte_w(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--)
      bit_x(b[i], nak);
    bit_x(1'b1, nak);
  endtask : byte_w

  task automatic byte_r(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(nak, r);  // Acknowledge continues, not-acknowledge ends
  endtask : byte_r

  task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d);
    logic k;
    st();
    byte_w({a, 1'b0}, k);
    chk("address ack", 8'h00, {7'h00, k});
    byte_w(o, k);
    byte_w(d, k);
    chk("data ack", 8'h00, {7'h00, k});
    sp();
  endtask : wr

  task automatic rd(input logic [7:0] o, output logic [7:0] d);
    logic k;
    st();
    byte_w({`ADDR_OWN, 1'b0}, k);
    byte_w(o, k);
    st();
    byte_w({`ADDR_OWN, 1'b1}, k);
    chk("read ack", 8'h00, {7'h00, k});
    byte_r(1'b1, d);
    sp();
  endtask : rd

  // Length of a high run of one stage bit
  task automatic meas(input int s, output int n);
    n = 0;
    while (stage[s] !== 1'b1)
      w(1);
    while (stage[s] === 1'b1)
    begin
      n++;
      w(1);
    end
  endtask : meas

  // Cycles until a stage bit rises
  task automatic gap(input int s, output int n);
    n = 0;
    while (stage[s] !== 1'b1)
    begin
      n++;
      w(1);
    end
  endtask : gap

  task automatic t_regs;
    logic [7:0] d;
    logic       k;
    chk("full scale reset", `RST_STEADY, full);
    rd(`OFS_PEAK, d);
    chk("peak reset", `RST_PEAK, d);
    rd(`OFS_TIMING, d);
    chk("timing reset", 8'h05, d);
    st();
    byte_w({`ADDR_OWN, 1'b0}, k);
    byte_w(`OFS_STEADY, k);
    st();
    byte_w({`ADDR_OWN, 1'b1}, k);
    byte_r(1'b0, d);
    chk("sequential first", `RST_STEADY, d);
    byte_r(1'b1, d);
    chk("sequential next", `RST_PEAK, d);
    sp();
    rd(8'h30, d);
    chk("unmapped read", 8'h00, d);
    wr(`ADDR_BCAST, `OFS_STEADY, 8'h5C);
    rd(`OFS_STEADY, d);
    chk("broadcast write", 8'h5C, d);
    st();
    byte_w(8'h66, k);
    chk("foreign address nack", 8'h01, {7'h00, k});
    sp();
  endtask : t_regs

  task automatic t_level;
    wr(`ADDR_OWN, `OFS_STEADY, 8'h90);
    w(4);
    chk("steady above peak", 8'h80, full);
    wr(`ADDR_OWN, `OFS_STEADY, 8'h30);
    w(4);
    chk("closed loop level", 8'h30, full);
    wr(`ADDR_OWN, `OFS_LOOP, 8'h01);
    w(4);
    chk("open loop level", 8'h80, full);
    wr(`ADDR_OWN, `OFS_LOOP, 8'h00);
    wr(`ADDR_OWN, `OFS_PEAK, 8'h20);
    w(4);
    chk("peak bounds level", 8'h20, full);
    wr(`ADDR_OWN, `OFS_PEAK, 8'h80);
  endtask : t_level

  task automatic t_seq;
    int n;
    int m;
    wr(`ADDR_OWN, `OFS_DRIVE, 8'h03);
    wr(`ADDR_OWN, `OFS_TIMING, 8'h06);
    wr(`ADDR_OWN, `OFS_MODE, 8'h00);
    wr(`ADDR_BCAST, `OFS_GO, 8'h01);
    meas(3, n);
    near("drive half period", 16, n);
    gap(1, n);
    near("decay interval", 3000, n);
    gap(0, n);
    near("settle wait", 2000, n);
    meas(2, n);
    near("flipped half period", 16, n);
    chk("busy running", 8'h01, {7'h00, busy});
    wr(`ADDR_OWN, `OFS_GO, 8'h00);
    wr(`ADDR_OWN, `OFS_ACT, 8'h80);
    late = 1'b1;
    slow = 1'b1;
    wr(`ADDR_OWN, `OFS_GO, 8'h01);
    meas(3, n);
    meas(2, m);
    chk("late lengthens", 8'h01, {7'h00, m > n});
    wr(`ADDR_OWN, `OFS_GO, 8'h00);
    w(4);
    chk("go clear stops", 8'h00, {7'h00, busy});
  endtask : t_seq

  task automatic t_open;
    int n;
    wr(`ADDR_OWN, `OFS_LOOP, 8'h01);
    wr(`ADDR_OWN, `OFS_GO, 8'h01);
    meas(3, n);
    near("open half period", 16, n);
    gap(2, n);
    near("no sensing gap", 0, n);
    meas(2, n);
    near("open other half", 16, n);
    wr(`ADDR_OWN, `OFS_GO, 8'h00);
    wr(`ADDR_OWN, `OFS_LOOP, 8'h00);
  endtask : t_open

  task automatic t_short;
    int n;
    out_short = 1'b1;
    w(20);
    chk("idle short hidden", 8'h00, {7'h00, flag});
    wr(`ADDR_OWN, `OFS_GO, 8'h01);
    w(6);
    chk("short at attempt", 8'h01, {7'h00, flag});
    chk("no run on short", 8'h00, {7'h00, busy});
    out_short = 1'b0;
    w(6);
    chk("flag released", 8'h00, {7'h00, flag});
    wr(`ADDR_OWN, `OFS_GO, 8'h01);
    gap(3, n);
    out_short = 1'b1;
    w(30);
    chk("flag held", 8'h01, {7'h00, flag});
    chk("current cut", 8'h00, {6'h00, stage.drive_p, stage.drive_n});
    out_short = 1'b0;
    w(6);
    chk("flag cleared", 8'h00, {7'h00, flag});
  endtask : t_short

  task automatic t_modes;
    logic [2:0] md [3] = '{`MODE_CAL, `MODE_DIAG, 3'h1};
    wr(`ADDR_OWN, `OFS_STEADY, 8'h50);
    wr(`ADDR_OWN, `OFS_PEAK, 8'h90);
    foreach (md[i])
    begin
      wr(`ADDR_OWN, `OFS_MODE, {5'h00, md[i]});
      wr(`ADDR_OWN, `OFS_GO, 8'h01);
      w(4);
      chk("mode runs", {7'h00, i < 2}, {7'h00, busy});
      wr(`ADDR_OWN, `OFS_GO, 8'h00);
    end
  endtask : t_modes

  task automatic t_regshort;
    logic [7:0] d;
    wr(`ADDR_OWN, `OFS_MODE, 8'h00);
    wr(`ADDR_OWN, `OFS_GO, 8'h01);
    w(10);
    reg_short = 1'b1;
    w(10);
    chk("shut down", 8'h00, {7'h00, busy});
    reg_short = 1'b0;
    w(10);
    rd(`OFS_STEADY, d);
    chk("steady default", `RST_STEADY, d);
    rd(`OFS_MODE, d);
    chk("mode default", 8'h40, d);
  endtask : t_regshort

  initial
  begin
    w(10);
    nrst = 1'b1;
    w(6);
    t_regs();
    t_level();
    t_seq();
    t_open();
    t_short();
    t_modes();
    t_regshort();
    results();
  end
endmodule : test_haptic_drive_loop_control
`default_nettype wire
